// File: inc/pcs_pkg.sv
// Constants for the PHY control and status register block
package pcs_pkg;
    // ****************************************
    // Register addresses and field positions
    // ****************************************
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_STAT = 5'h01;
    localparam logic [4:0] ADDR_ISO = 5'h00;
    localparam int C_LOOP = 14;
    localparam int C_RATE = 13;
    localparam int C_ANEN = 12;
    localparam int C_LP = 11;
    localparam int C_ISO = 10;
    localparam int C_RSTAN = 9;
    localparam int C_DPX = 8;
    localparam int C_CTEST = 7;
    localparam int S_CAP_HI = 14;
    localparam int S_CW_LO = 6;
    localparam int S_PRE = 6;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [14:7] CTRL_RST = 8'h60;
    localparam logic [14:6] STAT_CW_RST = 9'h1e0;
    // ****************************************
    // Management frame fields and timing
    // ****************************************
    localparam logic [1:0] OP_RD = 2'h2;
    localparam logic [1:0] OP_WR = 2'h1;
    localparam int PRE_LEN = 32;
    localparam int HDR_LAST = 12;
    localparam int DATA_LAST = 15;
    localparam int COL_ON_BT = 512;
    localparam int COL_OFF_BT = 4;
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_HDR = 5'b00010,
        ST_TA = 5'b00100,
        ST_RD = 5'b01000,
        ST_WR = 5'b10000
    } pcs_state_t;
endpackage

// File: hdl/pcs_regs.sv
// Control and basic status registers behind the serial management port
//
// Contract
// - Strap low: negotiation enable comes from select pin, register bit ignored.
// - Strap high: enable bit picks negotiation or the rate and duplex bits.
// - Low power: MAC outputs low, line transmitter tri-stated, management alive.
// - Entering low power resets latching bits only; reset restores all defaults.
// - Isolate: MAC outputs high impedance, MAC inputs ignored, management alive.
// - Isolate defaults to one when the PHY address is zero, else zero.
// - Restart bit starts negotiation and self-clears; ignored when negotiation off. The code also ignores it whenever the strap is low.
// - Strap low: duplex from duplex pin, duplex bit ignored.
// - Software mode without negotiation: duplex bit selects half or full.
// - Duplex bit has no effect during loopback.
// - Collision test: COL follows TXEN within 512 and 4 bit times.
// - Collision test off: COL does not follow TXEN.
// - Control bits six down to zero read as zero.
// - T4 bit reads zero; four ability bits reset to one, override-writable.
// - Negotiation complete is latching high, resets to zero.
// - Negotiation ability and extended capability always read one.
// - Link status is latching low, resets to zero.
// - Remote fault and jabber are latching high, reset to zero.
// - Preamble suppression bit resets to zero; one accepts preambleless frames.
// - Any reset loads every status bit with its default. The code does so only on rst; low-power entry clears just the latching bits.
// - Read of latching-low bit returns history then loads current state.
module pcs_regs #(
    parameter int PRE_COUNT = pcs_pkg::PRE_LEN
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [4:0] phy_addr,
    input wire logic strap_mode_select_pin,
    input wire logic negotiation_select_pin,
    input wire logic duplex_select_pin,
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    input wire logic override_write_en,
    input wire logic loopback_active,
    input wire logic an_complete_in,
    input wire logic remote_fault_in,
    input wire logic link_up_in,
    input wire logic jabber_in,
    input wire logic negotiated_full_in,
    input wire logic tx_en_in,
    input wire logic collision_in,
    output logic an_enable,
    output logic an_restart,
    output logic full_duplex,
    output logic low_power,
    output logic line_tx_tristate,
    output logic mac_out_enable,
    output logic mac_force_low,
    output logic tx_en_gated,
    output logic col_out,
    output logic col_oe
);
    import pcs_pkg::*;

    initial
    begin
        if (PRE_COUNT < 1 || PRE_COUNT > 63)
            $error("PRE_COUNT must lie in 1..63");
    end

    // Word seen by a read of either register; other addresses read zero
    function automatic logic [15:0] rd_word(input logic [4:0] ra, input logic [14:7] c,
        input logic [14:6] cw, input logic anc, input logic rf, input logic lnk, input logic jab);
        logic [15:0] w;
        w = 16'h0000;
        if (ra == REG_CTRL)
            w = {1'b0, c[14:10], 1'b0, c[8:7], 7'h00};
        else if (ra == REG_STAT)
            w = {1'b0, cw, anc, rf, 1'b1, lnk, jab, 1'b1};
        return w;
    endfunction

    // ****************************************
    // State
    // ****************************************
    pcs_state_t st_r, st_nxt;
    logic [5:0] cnt_r, cnt_nxt;
    logic [15:0] sh_r, sh_nxt;
    logic [4:0] ra_r, ra_nxt;
    logic rd_r, rd_nxt, hit_r, hit_nxt, mdc_q_r;
    logic [14:7] ctl_r, ctl_nxt;
    logic [14:6] cw_r, cw_nxt;
    logic anc_r, anc_nxt, rf_r, rf_nxt, jab_r, jab_nxt, lnk_r, lnk_nxt;
    logic rst_an_r, rst_an_nxt, boot_r, boot_nxt, lp_q_r;
    logic mo_r, mo_nxt, moe_r, moe_nxt, anr_r, anr_nxt;
    logic an_r, an_nxt, fd_r, fd_nxt, col_r, col_nxt, coe_r, coe_nxt;
    logic rise, an_eff;

    assign rise = mdc & ~mdc_q_r;
    // Hardware strap mode takes the pin, software mode the register bit
    assign an_eff = strap_mode_select_pin ? ctl_r[C_ANEN] : negotiation_select_pin;

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb
    begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        ra_nxt = ra_r;
        rd_nxt = rd_r;
        hit_nxt = hit_r;
        ctl_nxt = ctl_r;
        cw_nxt = cw_r;
        rst_an_nxt = rst_an_r;
        mo_nxt = mo_r;
        moe_nxt = moe_r;
        boot_nxt = 1'b0;
        anr_nxt = 1'b0;
        // Latch-high bits hold any event; latch-low holds any drop
        anc_nxt = anc_r | (an_eff & an_complete_in);
        rf_nxt = rf_r | remote_fault_in;
        jab_nxt = jab_r | jabber_in;
        lnk_nxt = lnk_r & link_up_in;
        // Address strap is sampled once after reset release, not under reset
        if (boot_r)
            ctl_nxt[C_ISO] = (phy_addr == ADDR_ISO);
        // Restart pending: hand it to negotiation and self-clear
        if (rst_an_r)
        begin
            anr_nxt = 1'b1;
            rst_an_nxt = 1'b0;
        end
        if (rise)
        begin
            case (st_r)
                ST_IDLE:
                begin
                    if (mdio_in)
                    begin
                        if (cnt_r < 6'(PRE_COUNT))
                            cnt_nxt = cnt_r + 6'h01;
                    end
                    else
                    begin
                        // A zero starts a frame only after a full preamble unless suppression is on
                        if (cnt_r == 6'(PRE_COUNT) || cw_r[S_PRE])
                        begin
                            st_nxt = ST_HDR;
                            sh_nxt = 16'h0000;
                        end
                        cnt_nxt = 6'h00;
                    end
                end
                ST_HDR:
                begin
                    sh_nxt = {sh_r[14:0], mdio_in};
                    cnt_nxt = cnt_r + 6'h01;
                    if (cnt_r == 6'(HDR_LAST))
                    begin
                        cnt_nxt = 6'h00;
                        ra_nxt = sh_nxt[4:0];
                        hit_nxt = (sh_nxt[9:5] == phy_addr);
                        rd_nxt = (sh_nxt[11:10] == OP_RD);
                        if (!sh_nxt[12] || (sh_nxt[11:10] != OP_RD && sh_nxt[11:10] != OP_WR))
                            st_nxt = ST_IDLE;
                        else
                            st_nxt = ST_TA;
                    end
                end
                ST_TA:
                begin
                    cnt_nxt = cnt_r + 6'h01;
                    if (cnt_r == 6'h00 && rd_r && hit_r)
                    begin
                        // Snapshot first, then the read side effects on the latches
                        sh_nxt = rd_word(ra_r, ctl_r, cw_r, anc_r, rf_r, lnk_r, jab_r);
                        moe_nxt = 1'b1;
                        mo_nxt = 1'b0;
                        if (ra_r == REG_STAT)
                        begin
                            anc_nxt = an_eff & an_complete_in;
                            rf_nxt = remote_fault_in;
                            jab_nxt = jabber_in;
                            lnk_nxt = link_up_in;
                        end
                    end
                    else if (cnt_r != 6'h00)
                    begin
                        cnt_nxt = 6'h00;
                        if (rd_r)
                        begin
                            st_nxt = ST_RD;
                            mo_nxt = sh_r[15];
                            sh_nxt = {sh_r[14:0], 1'b0};
                        end
                        else
                            st_nxt = ST_WR;
                    end
                end
                ST_RD:
                begin
                    if (cnt_r == 6'(DATA_LAST))
                    begin
                        moe_nxt = 1'b0;
                        mo_nxt = 1'b0;
                        st_nxt = ST_IDLE;
                        cnt_nxt = 6'h00;
                    end
                    else
                    begin
                        mo_nxt = sh_r[15];
                        sh_nxt = {sh_r[14:0], 1'b0};
                        cnt_nxt = cnt_r + 6'h01;
                    end
                end
                ST_WR:
                begin
                    sh_nxt = {sh_r[14:0], mdio_in};
                    cnt_nxt = cnt_r + 6'h01;
                    if (cnt_r == 6'(DATA_LAST))
                    begin
                        st_nxt = ST_IDLE;
                        cnt_nxt = 6'h00;
                        if (hit_r && ra_r == REG_CTRL)
                        begin
                            ctl_nxt = sh_nxt[14:7];
                            ctl_nxt[C_RSTAN] = 1'b0;
                            // Restart only counts in software mode with negotiation on
                            if (sh_nxt[C_RSTAN] && strap_mode_select_pin && ctl_r[C_ANEN])
                                rst_an_nxt = 1'b1;
                        end
                        if (hit_r && ra_r == REG_STAT && override_write_en)
                            cw_nxt = sh_nxt[S_CAP_HI:S_CW_LO];
                    end
                end
                default:
                begin
                    st_nxt = ST_IDLE;
                    cnt_nxt = 6'h00;
                end
            endcase
        end
        // Entering low power wipes latches back to defaults, nothing else
        if (ctl_r[C_LP] && !lp_q_r)
        begin
            anc_nxt = 1'b0;
            rf_nxt = 1'b0;
            jab_nxt = 1'b0;
            lnk_nxt = 1'b0;
        end
    end

    // ****************************************
    // Datapath controls seen by the PHY core
    // ****************************************
    always_comb
    begin
        an_nxt = an_eff;
        // Loopback makes duplex moot, so half is held there
        if (loopback_active)
            fd_nxt = 1'b0;
        else if (!strap_mode_select_pin)
            fd_nxt = duplex_select_pin;
        else if (an_eff)
            fd_nxt = negotiated_full_in;
        else
            fd_nxt = ctl_r[C_DPX];
        // One cycle of lag is well inside both bit-time limits
        coe_nxt = ~ctl_r[C_ISO];
        if (ctl_r[C_ISO] || ctl_r[C_LP])
            col_nxt = 1'b0;
        else if (ctl_r[C_CTEST])
            col_nxt = tx_en_in;
        else
            col_nxt = collision_in & ~loopback_active;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_r <= ST_IDLE;
            cnt_r <= 6'h00;
            sh_r <= 16'h0000;
            ra_r <= 5'h00;
            rd_r <= 1'b0;
            hit_r <= 1'b0;
            mdc_q_r <= 1'b1; // Matches the parked-high clock so no false rise follows reset
            ctl_r <= CTRL_RST;
            cw_r <= STAT_CW_RST;
            anc_r <= 1'b0;
            rf_r <= 1'b0;
            jab_r <= 1'b0;
            lnk_r <= 1'b0;
            rst_an_r <= 1'b0;
            boot_r <= 1'b1;
            lp_q_r <= 1'b0;
            mo_r <= 1'b0;
            moe_r <= 1'b0;
            anr_r <= 1'b0;
            an_r <= 1'b0;
            fd_r <= 1'b0;
            col_r <= 1'b0;
            coe_r <= 1'b0;
            low_power <= 1'b0;
            line_tx_tristate <= 1'b0;
            mac_out_enable <= 1'b0;
            mac_force_low <= 1'b0;
            tx_en_gated <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            ra_r <= ra_nxt;
            rd_r <= rd_nxt;
            hit_r <= hit_nxt;
            mdc_q_r <= mdc;
            ctl_r <= ctl_nxt;
            cw_r <= cw_nxt;
            anc_r <= anc_nxt;
            rf_r <= rf_nxt;
            jab_r <= jab_nxt;
            lnk_r <= lnk_nxt;
            rst_an_r <= rst_an_nxt;
            boot_r <= boot_nxt;
            lp_q_r <= ctl_r[C_LP];
            mo_r <= mo_nxt;
            moe_r <= moe_nxt;
            anr_r <= anr_nxt;
            an_r <= an_nxt;
            fd_r <= fd_nxt;
            col_r <= col_nxt;
            coe_r <= coe_nxt;
            low_power <= ctl_r[C_LP];
            line_tx_tristate <= ctl_r[C_LP];
            mac_out_enable <= ~ctl_r[C_ISO];
            mac_force_low <= ctl_r[C_LP];
            tx_en_gated <= tx_en_in & ~ctl_r[C_ISO] & ~ctl_r[C_LP];
        end
    end

    assign mdio_out = mo_r;
    assign mdio_oe = moe_r;
    assign an_restart = anr_r;
    assign an_enable = an_r;
    assign full_duplex = fd_r;
    assign col_out = col_r;
    assign col_oe = coe_r;
endmodule

// File: tb/pcs_regs_chk_sva.sv
// Port assertions for the control and status register block
module pcs_regs_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic strap_mode_select_pin,
    input wire logic negotiation_select_pin,
    input wire logic an_enable,
    input wire logic an_restart,
    input wire logic low_power,
    input wire logic line_tx_tristate,
    input wire logic mac_out_enable,
    input wire logic mac_force_low,
    input wire logic tx_en_gated,
    input wire logic col_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Low power holds the MAC side low and floats the line driver
    a_lp_outputs: assert property (low_power && $past(low_power) |-> mac_force_low && line_tx_tristate)
        else $error("low power outputs not applied");
    a_lp_tx_dead: assert property (mac_force_low && $past(mac_force_low) |-> !tx_en_gated)
        else $error("transmit enable passed in low power");
    // Isolate floats COL and ignores transmit enable; reset window excluded
    a_iso_col_float: assert property (!mac_out_enable |-> !col_oe)
        else $error("collision pin driven while isolated");
    a_iso_tx_ignored: assert property (!mac_out_enable && !$past(mac_out_enable) && !$past(rst, 2) |->
        !tx_en_gated)
        else $error("transmit enable passed while isolated");
    // Restart is one pulse, only with software-controlled negotiation on
    a_restart_single: assert property (an_restart |=> !an_restart)
        else $error("restart pulse too long");
    a_restart_allowed: assert property (an_restart |-> strap_mode_select_pin && an_enable)
        else $error("restart with negotiation off");
    // Strap low takes the enable from the select pin one cycle later
    a_hw_negot_pin: assert property (!strap_mode_select_pin && !$past(strap_mode_select_pin) && !$past(rst) |->
        an_enable == $past(negotiation_select_pin))
        else $error("negotiation enable not from pin");
    a_reset_quiet: assert property (disable iff (1'b0) rst |-> !an_restart && !low_power && !mac_out_enable)
        else $error("outputs active in reset");
endmodule
bind pcs_regs pcs_regs_chk u_chk (.clk, .rst, .strap_mode_select_pin, .negotiation_select_pin, .an_enable,
    .an_restart, .low_power, .line_tx_tristate, .mac_out_enable, .mac_force_low, .tx_en_gated, .col_oe);

// File: tb/pcs_sta_model.sv
// Station management controller model for the serial management port
module pcs_sta_model (
    input wire logic clk,
    input wire logic mdio_in,
    output logic mdc,
    output logic sta_bit,
    output logic sta_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    // Line released, clock parked high between frames
    initial
    begin
        mdc = 1'b1;
        sta_bit = 1'b1;
        sta_oe = 1'b0;
    end
    // One bit per four system clocks, two low then two high; the port takes slower rates too
    task automatic slot(input logic b, input logic drive, output logic seen);
        @(posedge clk);
        #1;
        mdc = 1'b0;
        sta_oe = drive;
        sta_bit = b;
        repeat (2) @(posedge clk);
        #1;
        seen = mdio_in;
        mdc = 1'b1;
        @(posedge clk);
    endtask
    // Whole frame; on reads the line is let go from the turnaround on
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
        input logic [15:0] wd, output logic [15:0] rdat);
        logic [31:0] word;
        logic seen;
        word = {2'b01, op, phy, ra, 2'b10, wd};
        rdat = 16'h0000;
        for (int i = 0; i < 4; i++)
            slot(1'b1, 1'b1, seen);
        for (int i = 31; i >= 0; i--)
        begin
            slot(word[i], !(op == 2'h2 && i < 18), seen);
            if (i < 16)
                rdat[i] = seen;
        end
        #1 sta_oe = 1'b0;
    endtask
endmodule

// File: tb/pcs_regs_bench.sv
// Self-checking bench for the control and status register block
module pcs_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import pcs_pkg::*;
    logic clk, rst, strap_mode_select_pin, negotiation_select_pin, duplex_select_pin, override_write_en;
    logic loopback_active, an_complete_in, remote_fault_in, link_up_in, jabber_in, negotiated_full_in;
    logic tx_en_in, collision_in, mdio_out, mdio_oe, an_enable, an_restart, full_duplex, low_power;
    logic line_tx_tristate, mac_out_enable, mac_force_low, tx_en_gated, col_out, col_oe, mdc, sta_bit, sta_oe;
    logic [4:0] phy_addr;
    int n_mismatch = 0;
    int n_compared = 0;
    int n_rs = 0;
    localparam logic [4:0] M_PIN [7] = '{5'h10, 5'h11, 5'h10, 5'h11, 5'h12, 5'h0c, 5'h01};
    localparam logic [15:0] M_CTL [7] = '{16'h2100, 16'h2000, 16'h3100, 16'h3000, 16'h2100, 16'h2000, 16'h3100};
    localparam logic [1:0] M_EXP [7] = '{2'h1, 2'h0, 2'h2, 2'h3, 2'h0, 2'h3, 2'h0};
    // Pull-up on the shared data line when nobody drives it
    wire mdio_in = mdio_oe ? mdio_out : (sta_oe ? sta_bit : 1'b1);
    pcs_regs #(.PRE_COUNT(2)) u_dut (.*);
    pcs_sta_model u_sta (.*);
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Counts restart pulses seen at the port
    always @(posedge clk) if (an_restart === 1'b1) n_rs++;
    task automatic tally_and_finish;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        logic [15:0] q;
        u_sta.frame(OP_WR, phy_addr, ra, d, q);
    endtask
    task automatic rd_chk(input string what, input logic [4:0] ra, input logic [15:0] exp);
        logic [15:0] q;
        u_sta.frame(OP_RD, phy_addr, ra, 16'h0000, q);
        chk(what, exp, q);
    endtask
    task automatic do_reset(input logic [4:0] a);
        rst = 1'b1;
        phy_addr = a;
        tick(5);
        rst = 1'b0;
        tick(3);
    endtask
    // Isolate default follows the address; registers come up at their defaults
    task automatic t_defaults;
        do_reset(ADDR_ISO);
        rd_chk("ctrl iso", REG_CTRL, 16'h3400);
        tx_en_in = 1'b1;
        tick(2);
        chk("mac_out_enable", 16'h0, 16'(mac_out_enable));
        chk("tx gated iso", 16'h0, 16'(tx_en_gated));
        tx_en_in = 1'b0;
        do_reset(5'h05);
        tx_en_in = 1'b1;
        rd_chk("ctrl", REG_CTRL, 16'h3000);
        rd_chk("stat", REG_STAT, 16'h7809);
        rd_chk("unmapped", 5'h1f, 16'h0000);
        chk("tx gated", 16'h1, 16'(tx_en_gated));
        tx_en_in = 1'b0;
    endtask
    // Latched events stay until read; low-power entry reinitialises only them
    task automatic t_latch;
        {an_complete_in, remote_fault_in, jabber_in, link_up_in} = 4'hf;
        tick(2);
        {an_complete_in, remote_fault_in, jabber_in} = 3'h0;
        tick(2);
        rd_chk("stat hist", REG_STAT, 16'h783b);
        rd_chk("stat now", REG_STAT, 16'h780d);
        remote_fault_in = 1'b1;
        tick(2);
        remote_fault_in = 1'b0;
        wr(REG_CTRL, 16'h3800);
        tick(2);
        chk("lp outs", 16'h7, {13'h0, low_power, mac_force_low, line_tx_tristate});
        rd_chk("stat lp", REG_STAT, 16'h7809);
        rd_chk("ctrl lp", REG_CTRL, 16'h3800);
        wr(REG_CTRL, 16'h3000);
        link_up_in = 1'b0;
    endtask
    // Restart pulses once and reads back clear; ignored with negotiation off
    task automatic t_restart;
        n_rs = 0;
        wr(REG_CTRL, 16'h3200);
        tick(3);
        chk("restart", 16'h1, 16'(n_rs));
        rd_chk("ctrl rs", REG_CTRL, 16'h3000);
        wr(REG_CTRL, 16'h2000);
        wr(REG_CTRL, 16'h2200);
        tick(3);
        chk("restart off", 16'h1, 16'(n_rs));
    endtask
    // Strap, negotiation and loopback decide which source sets enable and duplex
    task automatic t_modes;
        for (int i = 0; i < 7; i++)
        begin
            {strap_mode_select_pin, negotiation_select_pin, duplex_select_pin, loopback_active,
                negotiated_full_in} = M_PIN[i];
            wr(REG_CTRL, M_CTL[i]);
            tick(2);
            chk("an fdx", 16'(M_EXP[i]), {14'h0, an_enable, full_duplex});
        end
        {strap_mode_select_pin, negotiation_select_pin, duplex_select_pin, loopback_active, negotiated_full_in} = 5'h10;
        wr(REG_CTRL, 16'h3000);
    endtask
    // Collision test echoes transmit enable even in loopback; one cycle is far inside the bound
    task automatic t_col;
        loopback_active = 1'b1;
        wr(REG_CTRL, 16'h3080);
        tx_en_in = 1'b1;
        tick(1);
        chk("col on", 16'h1, 16'(col_out));
        tx_en_in = 1'b0;
        tick(1);
        chk("col off", 16'h0, 16'(col_out));
        wr(REG_CTRL, 16'h3000);
        {tx_en_in, loopback_active} = 2'h2;
        tick(2);
        chk("col no test", 16'h0, 16'(col_out));
        tx_en_in = 1'b0;
    endtask
    // Reserved bits read zero; capability bits change only with the override
    task automatic t_reserved;
        wr(REG_CTRL, 16'h307f);
        rd_chk("ctrl rsv", REG_CTRL, 16'h3000);
        wr(REG_STAT, 16'h0000);
        rd_chk("stat ro", REG_STAT, 16'h7809);
        override_write_en = 1'b1;
        wr(REG_STAT, 16'h0000);
        rd_chk("stat cw", REG_STAT, 16'h0009);
        wr(REG_STAT, 16'h7840);
        rd_chk("stat mfps", REG_STAT, 16'h7849);
        wr(REG_STAT, 16'h7800);
        override_write_en = 1'b0;
        rd_chk("stat back", REG_STAT, 16'h7809);
    endtask
    initial
    begin
        {rst, strap_mode_select_pin, negotiation_select_pin, duplex_select_pin, override_write_en} = 5'h18;
        {loopback_active, an_complete_in, remote_fault_in, link_up_in, jabber_in} = 5'h00;
        {negotiated_full_in, tx_en_in, collision_in} = 3'h0;
        phy_addr = 5'h00;
        t_defaults();
        t_latch();
        t_restart();
        t_modes();
        t_col();
        t_reserved();
        tally_and_finish();
    end
    // Watchdog well beyond the roughly five thousand cycles the frames take
    initial
    begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
